// >>> bench/mis_line_model.sv
// Model of the MAC transmit datapath and carrier pin facing the block.
// Assumes its tasks are called just after a rising edge of pclk.
`timescale 1ns/1ps
`default_nettype none

module mis_line_model (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Reset, active low
    input wire logic tx_abort, // Abort request from block
    input wire logic tx_retransmit, // Retransmit request from block
    output var mis_pkg::mis_line_t line, // Line activity
    output var logic carrier_sense // Carrier sense pin
);
    int abort_count;
    int retry_count;

    // Quiet line with carrier present
    initial
    begin
        line = '0;
        carrier_sense = 1'b1;
    end

    // Count high cycles, so a stretched request shows as an extra count
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            abort_count <= 0;
            retry_count <= 0;
        end
        else
        begin
            abort_count <= abort_count + int'(tx_abort);
            retry_count <= retry_count + int'(tx_retransmit);
        end
    end

    // One-cycle strobes on field f, a gap after each
    task automatic strobe(input int f, input int n);
        repeat (n)
        begin
            line[f] <= 1'b1;
            @(posedge pclk);
            line[f] <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // Deferral held for n cycles
    task automatic hold(input int n);
        line.deferring <= 1'b1;
        repeat (n) @(posedge pclk);
        line.deferring <= 1'b0;
        @(posedge pclk);
    endtask

    // Transmission of n cycles with the given carrier level
    task automatic send(input int n, input logic crs);
        carrier_sense <= crs;
        line.transmitting <= 1'b1;
        repeat (n) @(posedge pclk);
        line.transmitting <= 1'b0;
        carrier_sense <= 1'b1;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// >>> bench/test_mac_interrupt_status_mask.sv
// Self-checking bench for the MAC interrupt status block.
// Assumes mis_pkg, the design and the line model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "mis_defines.svh"

module test_mac_interrupt_status_mask;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, carrier_sense;
    logic tx_irq, rx_irq, halted, tx_abort, tx_retransmit;
    mis_pkg::mis_tx_ev_t tx_ev = '0;
    mis_pkg::mis_line_t line;
    logic [14:1] rx_events = '0;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;

    // Short deferral limits keep the run brief
    mis_top #(.DEFER_100_CYC(20), .DEFER_10_CYC(40)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_ev(tx_ev), .line(line),
        .rx_events(rx_events), .carrier_sense(carrier_sense), .tx_irq(tx_irq),
        .rx_irq(rx_irq), .tx_dma_halted(halted), .tx_abort(tx_abort),
        .tx_retransmit(tx_retransmit)
    );

    mis_line_model mdl (
        .pclk(pclk), .presetn(presetn), .tx_abort(tx_abort),
        .tx_retransmit(tx_retransmit), .line(line), .carrier_sense(carrier_sense)
    );

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    // Cut a hang short; the whole run needs about 1100 cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            end_sim();
        end
    end

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic end_sim();
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen, ends one edge later
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        cmp_reg(rd, exp);
    endtask

    // Event pulses of one cycle
    task automatic ev(input logic [3:0] t, input logic [14:1] r);
        tx_ev <= t;
        rx_events <= r;
        @(posedge pclk);
        tx_ev <= '0;
        rx_events <= '0;
        @(posedge pclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rchk(`MIS_ADDR_ENABLE, `MIS_RESET_VALUE);
        rchk(`MIS_ADDR_STATUS, `MIS_RESET_VALUE);
        wr(`MIS_ADDR_ENABLE, 32'hFFFF_FFFF);
        rchk(`MIS_ADDR_ENABLE, `MIS_ENABLE_BITS);
        wr(`MIS_ADDR_STATUS, 32'hFFFF_FFFF);
        rchk(`MIS_ADDR_STATUS, 32'h0000_0000);
        rchk(32'hB000_30C0, 32'h0000_0000);
        cmp_flag(err, 1'b1);
    endtask

    task automatic t_tx();
        int pos [4] = '{17, 18, 23, 24};
        logic [31:0] m;
        for (int i = 0; i < 4; i++)
        begin
            m = 32'h0000_0001 << pos[i];
            wr(`MIS_ADDR_ENABLE, m);
            ev(4'h1 << i, '0);
            rchk(`MIS_ADDR_STATUS, m | 32'h0001_0000);
            cmp_flag(tx_irq, 1'b0);
            wr(`MIS_ADDR_ENABLE, m | 32'h0001_0000);
            repeat (2) @(posedge pclk);
            cmp_flag(tx_irq, 1'b1);
            wr(`MIS_ADDR_STATUS, 32'h0000_0000);
            rchk(`MIS_ADDR_STATUS, m | 32'h0001_0000);
            wr(`MIS_ADDR_STATUS, m);
            rchk(`MIS_ADDR_STATUS, 32'h0000_0000);
            cmp_flag(tx_irq, 1'b0);
        end
        cmp_flag(halted, 1'b1);
        rchk(`MIS_ADDR_DEMAND, 32'h0000_0001);
        wr(`MIS_ADDR_DEMAND, 32'h0000_0000);
        cmp_flag(halted, 1'b0);
        cmp_reg(32'(mdl.retry_count), 32'h0000_0001);
    endtask

    // Per-source gate, then master gate, for each implemented receive status
    task automatic t_rx();
        logic [31:0] m;
        for (int b = 1; b < 15; b++)
        begin
            if (b == 12 || b == 13)
                continue;
            m = 32'h0000_0001 << b;
            wr(`MIS_ADDR_ENABLE, 32'h0000_0001);
            ev(4'h0, m[14:1]);
            rchk(`MIS_ADDR_STATUS, m);
            cmp_flag(rx_irq, 1'b0);
            wr(`MIS_ADDR_ENABLE, m);
            rchk(`MIS_ADDR_STATUS, m | 32'h0000_0001);
            cmp_flag(rx_irq, 1'b0);
            wr(`MIS_ADDR_ENABLE, m | 32'h0000_0001);
            repeat (2) @(posedge pclk);
            cmp_flag(rx_irq, 1'b1);
            wr(`MIS_ADDR_STATUS, m);
            repeat (2) @(posedge pclk);
            cmp_flag(rx_irq, 1'b0);
        end
    endtask

    // Event lands on the very edge of the clearing write
    task automatic t_race();
        wr(`MIS_ADDR_ENABLE, 32'h0005_0000);
        ev(4'h2, '0);
        fork
            wr(`MIS_ADDR_STATUS, 32'h0004_0000);
            begin
                @(posedge pclk);
                ev(4'h2, '0);
            end
        join
        rchk(`MIS_ADDR_STATUS, 32'h0005_0000);
    endtask

    task automatic t_collide();
        wr(`MIS_ADDR_STATUS, `MIS_TX_EVENTS);
        wr(`MIS_ADDR_CONTROL, 32'h0000_0001);
        mdl.strobe(4, 1);
        mdl.strobe(3, 63);
        mdl.strobe(2, 1);
        rchk(`MIS_ADDR_STATUS, 32'h0000_0000);
        mdl.strobe(3, 1);
        mdl.strobe(2, 1);
        rchk(`MIS_ADDR_STATUS, 32'h0040_0000);
        mdl.strobe(4, 1);
        mdl.strobe(2, 15);
        rchk(`MIS_ADDR_STATUS, 32'h0040_0000);
        mdl.strobe(2, 1);
        rchk(`MIS_ADDR_STATUS, 32'h0060_0000);
        wr(`MIS_ADDR_STATUS, `MIS_TX_EVENTS);
        wr(`MIS_ADDR_CONTROL, 32'h0000_0000);
        mdl.strobe(4, 1);
        mdl.strobe(3, 64);
        mdl.strobe(2, 16);
        mdl.send(6, 1'b0);
        rchk(`MIS_ADDR_STATUS, 32'h0000_0000);
        cmp_reg(32'(mdl.abort_count), 32'h0000_0001);
    endtask

    task automatic t_carrier();
        wr(`MIS_ADDR_CONTROL, 32'h0000_0001);
        mdl.send(6, 1'b1);
        rchk(`MIS_ADDR_STATUS, 32'h0000_0000);
        mdl.send(6, 1'b0);
        rchk(`MIS_ADDR_STATUS, 32'h0010_0000);
        wr(`MIS_ADDR_STATUS, `MIS_TX_EVENTS);
    endtask

    // Control is {no defer, 100 Mb/s, half duplex}; limits 20 and 40 cycles
    task automatic t_defer();
        logic [2:0] ctl [6] = '{3'h3, 3'h3, 3'h1, 3'h1, 3'h7, 3'h2};
        int len [6] = '{19, 20, 39, 40, 50, 50};
        logic hit [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 6; i++)
        begin
            wr(`MIS_ADDR_CONTROL, {29'h0000_0000, ctl[i]});
            rchk(`MIS_ADDR_CONTROL, {29'h0000_0000, ctl[i]});
            mdl.hold(len[i]);
            rchk(`MIS_ADDR_STATUS, {12'h000, hit[i], 19'h0_0000});
            wr(`MIS_ADDR_STATUS, `MIS_TX_EVENTS);
        end
    endtask

    // Reset for three cycles, then every scenario in turn
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_tx();
        t_rx();
        t_race();
        t_collide();
        t_carrier();
        t_defer();
        end_sim();
    end
endmodule
`default_nettype wire

// >>> logic/mis_defines.svh
// Offsets, field positions, reset values and timing counts of the MAC interrupt status block.
// Assumes the includer compiles with the package mis_pkg alongside.
`ifndef MIS_DEFINES_SVH
`define MIS_DEFINES_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define MIS_ADDR_ENABLE 32'hB000_30AC
`define MIS_ADDR_STATUS 32'hB000_30B0
`define MIS_ADDR_DEMAND 32'hB000_30B4
`define MIS_ADDR_CONTROL 32'hB000_30B8
`define MIS_RESET_VALUE 32'h0000_0000

// ****************************************
// Field positions
// ****************************************
`define MIS_RX_SUMMARY 0
`define MIS_TX_SUMMARY 16
`define MIS_BIT_UNDERRUN 17
`define MIS_BIT_DONE 18
`define MIS_BIT_DEFER 19
`define MIS_BIT_CARRIER 20
`define MIS_BIT_ABORT 21
`define MIS_BIT_LATE 22
`define MIS_BIT_NODESC 23
`define MIS_BIT_DMAFAULT 24
`define MIS_RX_EVENTS 32'h0000_4FFE
`define MIS_TX_EVENTS 32'h01FE_0000
`define MIS_ENABLE_BITS 32'h01FF_4FFF
`define MIS_CTRL_BITS 32'h0000_0007

// ****************************************
// Timing
// ****************************************
`define MIS_CLK_NS 25
`define MIS_DEFER_100_NS 327680
`define MIS_DEFER_10_NS 3276800
`define MIS_LATE_BYTES 64
`define MIS_ABORT_COLLISIONS 16

`endif

// >>> logic/mis_pkg.sv
// Types shared by the MAC interrupt status block, its line model and its bench.
// Assumes mis_defines.svh is compiled with it.
package mis_pkg;

    // Transmit engine event pulses, one cycle each
    typedef struct packed {
        logic transmit_dma_fault;
        logic transmit_descriptor_missing;
        logic transmit_done;
        logic transmit_fifo_underrun;
    } mis_tx_ev_t;

    // Transmit line activity from the MAC datapath
    typedef struct packed {
        logic frame_start;
        logic byte_sent;
        logic collision;
        logic deferring;
        logic transmitting;
    } mis_line_t;

    // Operating mode bits held in the control register
    typedef struct packed {
        logic no_defer_control;
        logic speed_100;
        logic half_duplex;
    } mis_mode_t;

endpackage

// >>> logic/mis_sticky.sv
// One write-one-to-clear status flag.
// Assumes set and clear arrive on the same clock as the flag.
`timescale 1ns/1ps
`default_nettype none

module mis_sticky (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic set, // Event pulse
    input wire logic clr, // Clearing write of one
    output logic q // Latched flag
);

    // Set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= 1'b0;
        else if (set)
            q <= 1'b1;
        else if (clr)
            q <= 1'b0;
    end

endmodule

`default_nettype wire

// >>> logic/mis_top.sv
// MAC interrupt status and enable registers behind an APB slave.
// Assumes event inputs come from logic on pclk; only carrier sense is a pin.
`timescale 1ns/1ps
`default_nettype none
`include "mis_defines.svh"

module mis_top #(
    parameter int DEFER_100_CYC = (`MIS_DEFER_100_NS + `MIS_CLK_NS - 1) / `MIS_CLK_NS,
    parameter int DEFER_10_CYC = (`MIS_DEFER_10_NS + `MIS_CLK_NS - 1) / `MIS_CLK_NS
) (
    input wire logic pclk, // Bus clock, 40 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [31:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire mis_pkg::mis_tx_ev_t tx_ev, // Transmit event pulses
    input wire mis_pkg::mis_line_t line, // Transmit line activity
    input wire logic [14:1] rx_events, // Receive event pulses
    input wire logic carrier_sense, // Carrier sense pin, asynchronous
    output logic tx_irq, // Transmit interrupt request
    output logic rx_irq, // Receive interrupt request
    output logic tx_dma_halted, // Transmit DMA held in halt
    output logic tx_abort, // Abort current frame, pulse
    output logic tx_retransmit // Retransmit current frame, pulse
);

    // ****************************************
    // Bus decode
    // ****************************************
    logic [31:0] status;
    logic [31:0] enable;
    mis_pkg::mis_mode_t mode;
    logic [31:0] status_set;
    logic [31:0] status_view;
    logic tx_summary;
    logic rx_summary;
    logic setup;
    logic write_access;
    logic wr_status;
    logic wr_enable;
    logic wr_demand;
    logic wr_control;
    logic mapped;

    // Request is taken at the access edge; ready is high from the first edge after reset so one access phase
    assign setup = psel && !penable;
    assign write_access = psel && penable && pwrite && pready;
    assign wr_status = write_access && (paddr == `MIS_ADDR_STATUS);
    assign wr_enable = write_access && (paddr == `MIS_ADDR_ENABLE);
    assign wr_demand = write_access && (paddr == `MIS_ADDR_DEMAND);
    assign wr_control = write_access && (paddr == `MIS_ADDR_CONTROL);
    assign mapped = (paddr == `MIS_ADDR_STATUS) || (paddr == `MIS_ADDR_ENABLE)
        || (paddr == `MIS_ADDR_DEMAND) || (paddr == `MIS_ADDR_CONTROL);

    // Ready is a flop so that every output starts from a register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= 1'b1;
    end

    // Read data and error are captured in the setup cycle, valid through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= `MIS_RESET_VALUE;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            pslverr <= !mapped;
            if (pwrite || !mapped)
                prdata <= 32'h0000_0000;
            else if (paddr == `MIS_ADDR_STATUS)
                prdata <= status_view;
            else if (paddr == `MIS_ADDR_ENABLE)
                prdata <= enable;
            else if (paddr == `MIS_ADDR_CONTROL)
                prdata <= {29'h0000_0000, mode};
            else
                prdata <= {31'h0000_0000, tx_dma_halted};
        end
    end

    // ****************************************
    // Enable and control registers
    // ****************************************

    // Enable register; reserved bits stay zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enable <= `MIS_RESET_VALUE;
        else if (wr_enable)
            enable <= pwdata & `MIS_ENABLE_BITS;
    end

    // Duplex, speed and no-defer mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode <= '0;
        else if (wr_control)
            mode <= pwdata[2:0];
    end

    // ****************************************
    // Carrier sense synchroniser
    // ****************************************
    logic crs_meta;
    logic crs_sync;

    // Pin is asynchronous; only crs_sync is looked at
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            crs_meta <= 1'b0;
            crs_sync <= 1'b0;
        end
        else
        begin
            crs_meta <= carrier_sense;
            crs_sync <= crs_meta;
        end
    end

    // ****************************************
    // Transmit line checks
    // ****************************************
    logic [6:0] bytes_sent;
    logic [4:0] collisions;
    logic [17:0] defer_count;
    logic [17:0] defer_limit;
    logic late_event;
    logic abort_event;
    logic carrier_event;
    logic defer_event;

    // Byte count saturates once the collision window has passed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bytes_sent <= 7'h00;
        else if (line.frame_start)
            bytes_sent <= 7'h00;
        else if (line.byte_sent && bytes_sent < 7'(`MIS_LATE_BYTES))
            bytes_sent <= bytes_sent + 7'h01;
    end

    // Consecutive collisions on one frame; restart with each frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            collisions <= 5'h00;
        else if (line.frame_start || abort_event)
            collisions <= 5'h00;
        else if (line.collision && mode.half_duplex)
            collisions <= collisions + 5'h01;
    end

    assign late_event = mode.half_duplex && line.collision
        && bytes_sent >= 7'(`MIS_LATE_BYTES);
    assign abort_event = mode.half_duplex && line.collision
        && collisions == 5'(`MIS_ABORT_COLLISIONS - 1);
    assign carrier_event = mode.half_duplex && line.transmitting && !crs_sync;

    // Deferral timer; a long limit is a parameter so a bench can shorten it
    assign defer_limit = mode.speed_100 ? 18'(DEFER_100_CYC) : 18'(DEFER_10_CYC);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            defer_count <= 18'h0_0000;
        else if (!line.deferring)
            defer_count <= 18'h0_0000;
        else if (defer_count < defer_limit)
            defer_count <= defer_count + 18'h0_0001;
    end

    // Fires once, on the cycle the count stands one below the limit
    assign defer_event = mode.half_duplex && !mode.no_defer_control && line.deferring
        && defer_count == defer_limit - 18'h0_0001;

    // Abort and retransmit commands to the transmit engine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_abort <= 1'b0;
            tx_retransmit <= 1'b0;
        end
        else
        begin
            tx_abort <= abort_event;
            tx_retransmit <= tx_ev.transmit_fifo_underrun;
        end
    end

    // DMA stays halted until software demands a restart; new loss wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_dma_halted <= 1'b0;
        else if (tx_ev.transmit_descriptor_missing)
            tx_dma_halted <= 1'b1;
        else if (wr_demand)
            tx_dma_halted <= 1'b0;
    end

    // ****************************************
    // Status flags
    // ****************************************

    // Event pulses mapped onto status positions
    always_comb
    begin
        status_set = 32'h0000_0000;
        status_set[14:1] = rx_events;
        status_set[`MIS_BIT_DMAFAULT] = tx_ev.transmit_dma_fault;
        status_set[`MIS_BIT_NODESC] = tx_ev.transmit_descriptor_missing;
        status_set[`MIS_BIT_LATE] = late_event;
        status_set[`MIS_BIT_ABORT] = abort_event;
        status_set[`MIS_BIT_CARRIER] = carrier_event;
        status_set[`MIS_BIT_DEFER] = defer_event;
        status_set[`MIS_BIT_DONE] = tx_ev.transmit_done;
        status_set[`MIS_BIT_UNDERRUN] = tx_ev.transmit_fifo_underrun;
    end

    // One sticky cell per implemented event bit; others are tied to zero
    localparam logic [31:0] EVENT_BITS = `MIS_RX_EVENTS | `MIS_TX_EVENTS;

    generate
        for (genvar i = 0; i < 32; i++)
        begin : g_flag
            if (EVENT_BITS[i])
            begin : g_cell
                mis_sticky u_flag (
                    .pclk(pclk),
                    .presetn(presetn),
                    .set(status_set[i]),
                    .clr(wr_status && pwdata[i]),
                    .q(status[i])
                );
            end
            else
            begin : g_zero
                assign status[i] = 1'b0;
            end
        end
    endgenerate

    // Summaries are live ORs, so clearing sources clears them too
    assign tx_summary = |(status & enable & `MIS_TX_EVENTS);
    assign rx_summary = |(status & enable & `MIS_RX_EVENTS);

    // Read view with summaries placed; writes to them have no effect
    always_comb
    begin
        status_view = status;
        status_view[`MIS_TX_SUMMARY] = tx_summary;
        status_view[`MIS_RX_SUMMARY] = rx_summary;
    end

    // ****************************************
    // Interrupt requests
    // ****************************************

    // Registered so the requests are glitch free toward the CPU controller
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_irq <= 1'b0;
            rx_irq <= 1'b0;
        end
        else
        begin
            tx_irq <= enable[`MIS_TX_SUMMARY] && tx_summary;
            rx_irq <= enable[`MIS_RX_SUMMARY] && rx_summary;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_tx_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        tx_irq == $past(enable[16] && tx_summary))
    else $error("transmit request does not follow enable and summary");

    chk_rx_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (enable[0] && rx_summary) |=> rx_irq)
    else $error("receive request missing");

    chk_rx_master_off: assert property (@(posedge pclk) disable iff (!presetn)
        !enable[0] |=> !rx_irq)
    else $error("receive request while master enable clear");

    chk_tx_summary_or: assert property (@(posedge pclk) disable iff (!presetn)
        tx_summary == (|(status[24:17] & enable[24:17])))
    else $error("transmit summary mismatch");

    chk_rx_summary_or: assert property (@(posedge pclk) disable iff (!presetn)
        rx_summary == (|(status[14:1] & enable[14:1])))
    else $error("receive summary mismatch");

    chk_w1c_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_status && pwdata[18] && !tx_ev.transmit_done) |=> !status[18])
    else $error("write of one did not clear completion flag");

    chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (status[18] && !(wr_status && pwdata[18])) or tx_ev.transmit_done |=> status[18])
    else $error("completion flag lost");

    chk_abort_sixteen: assert property (@(posedge pclk) disable iff (!presetn)
        abort_event |=> (tx_abort && status[21]) ##1 !tx_abort)
    else $error("abort not reported after sixteen collisions");

    chk_late_window: assert property (@(posedge pclk) disable iff (!presetn)
        (mode.half_duplex && line.collision && bytes_sent == 7'h40) |=> status[22])
    else $error("late collision not latched");

    chk_halt_release: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_demand && !tx_ev.transmit_descriptor_missing) |=> !tx_dma_halted)
    else $error("DMA halt not released by start demand");

    chk_underrun_retx: assert property (@(posedge pclk) disable iff (!presetn)
        tx_ev.transmit_fifo_underrun |=> (tx_retransmit && status[17]))
    else $error("underrun did not request retransmission");

endmodule

`default_nettype wire
